// ### logic/cpu_clock_mode_pkg.sv
/*
 * Shared constants and types for the CPU clock mode selector: strap codes,
 * multiplication factors, watchdog limits and the decoded mode carrier.
 * Assumes a single system clock domain; no registers reachable by software.
 */
package cpu_clock_mode_pkg;

   // ----------------------------------------------------------------------
   // Strap codes
   // ----------------------------------------------------------------------
   localparam logic [2:0] CODE_X4       = 3'h7;
   localparam logic [2:0] CODE_X3       = 3'h6;
   localparam logic [2:0] CODE_X8       = 3'h5;
   localparam logic [2:0] CODE_X5       = 3'h4;
   localparam logic [2:0] CODE_DIRECT   = 3'h3;
   localparam logic [2:0] CODE_X10      = 3'h2;
   localparam logic [2:0] CODE_PRESCALE = 3'h1;
   localparam logic [2:0] CODE_X16      = 3'h0;
   localparam logic [2:0] CODE_DEFAULT  = CODE_X4;

   // ----------------------------------------------------------------------
   // Multiplication factors
   // ----------------------------------------------------------------------
   localparam logic [4:0] FACTOR_X1  = 5'h01;
   localparam logic [4:0] FACTOR_X3  = 5'h03;
   localparam logic [4:0] FACTOR_X4  = 5'h04;
   localparam logic [4:0] FACTOR_X5  = 5'h05;
   localparam logic [4:0] FACTOR_X8  = 5'h08;
   localparam logic [4:0] FACTOR_X10 = 5'h0a;
   localparam logic [4:0] FACTOR_X16 = 5'h10;
   localparam logic [4:0] FACTOR_NONE = 5'h00;

   // ----------------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------------
   localparam logic [4:0] WD_OVERFLOW  = 5'h10;
   // The strap level leaves the synchroniser on the fourth edge after release,
   // so the capture has to wait for the fifth.
   localparam logic [2:0] STRAP_SETTLE = 3'h4;

   // Decoded clock generation mode.
   typedef struct packed {
      logic       pll_clocks_cpu;
      logic       osc_bypass;
      logic       prescale;
      logic [4:0] factor;
   } clk_mode_t;

endpackage

// ### logic/pin_sync3.sv
/*
 * Three-stage synchroniser for pin inputs. The output level changes only
 * once the second and third stages agree. Assumes the input is static or
 * slow compared with the system clock.
 */
`timescale 1ns/1ns
module pin_sync3 #(
   parameter int             WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   // Pin side
   input  wire logic [WIDTH-1:0] pin_i,
   // Synchronised level
   output logic      [WIDTH-1:0] level_o
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;

   // The first stage feeds only the second; the agreement test uses 2 and 3.
   always_comb begin
      st_next     = st_reg;
      st_next.s1  = pin_i;
      st_next.s2  = st_reg.s1;
      st_next.s3  = st_reg.s2;
      if (st_reg.s2 == st_reg.s3) begin
         st_next.lvl = st_reg.s3;
      end
   end

   // State register.
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_o = st_reg.lvl;

endmodule

// ### logic/cpu_clock_mode_select.sv
/*
 * CPU clock mode selector. Latches the clock mode strap after reset, selects
 * PLL, direct drive or 2:1 prescaler as CPU clock source, and runs the
 * oscillator watchdog that fails over to the free-running PLL clock.
 * Assumes the PLL output arrives as a level sampled on sys_clk_i, and the
 * watchdog disable bit comes from a register on the same clock.
 */
`timescale 1ns/1ns
module cpu_clock_mode_select (
   // Clock and reset
   input  wire logic                           sys_clk_i,
   input  wire logic                           rst_n_i,
   // Pins
   input  wire logic [2:0]                     config_port_high_i,
   input  wire logic                           input_clock_pin_i,
   // PLL and configuration
   input  wire logic                           pll_out_i,
   input  wire logic                           osc_watchdog_disable_i,
   // Clock outputs
   output logic                                cpu_clk_o,
   output logic                                cpu_edge_o,
   // Mode and status
   output cpu_clock_mode_pkg::clk_mode_t       mode_o,
   output logic                                mode_valid_o,
   output logic                                pll_enable_o,
   output logic                                failover_o,
   output logic                                owd_irq_o
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic                          strap_ok;
      logic [2:0]                    code;
      logic [2:0]                    settle;
      logic                          in_prev;
      logic                          pll_prev;
      logic [4:0]                    wd_cnt;
      logic                          failover;
      logic                          irq;
      logic                          div_clk;
      logic                          cpu_clk;
      logic                          cpu_edge;
      cpu_clock_mode_pkg::clk_mode_t mode;
      logic                          pll_en;
   } cms_state_t;

   cms_state_t st_reg;
   cms_state_t st_next;

   logic [2:0] strap_lvl;
   logic       in_lvl;
   logic       in_edge;
   logic       in_rise;
   logic       pll_rise;
   logic       non_pll;
   logic       wd_active;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // The strap resets to the default code so an idle port selects x4.
   pin_sync3 #(
      .WIDTH   (3),
      .RST_VAL (cpu_clock_mode_pkg::CODE_DEFAULT)
   ) u_strap_sync (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (config_port_high_i),
      .level_o   (strap_lvl)
   );

   pin_sync3 #(
      .WIDTH   (1),
      .RST_VAL (1'b0)
   ) u_clk_sync (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (input_clock_pin_i),
      .level_o   (in_lvl)
   );

   // Edge detection on synchronised input and PLL levels.
   assign in_edge  = in_lvl != st_reg.in_prev;
   assign in_rise  = in_lvl && !st_reg.in_prev;
   assign pll_rise = pll_out_i && !st_reg.pll_prev;
   assign non_pll  = !st_reg.mode.pll_clocks_cpu;
   // The watchdog only guards modes that do not clock the CPU from the PLL.
   assign wd_active = st_reg.strap_ok && non_pll && !osc_watchdog_disable_i
                      && !st_reg.failover;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_next          = st_reg;
      st_next.in_prev  = in_lvl;
      st_next.pll_prev = pll_out_i;
      st_next.irq      = 1'b0;

      // Capture the strap once the synchroniser has filled, then freeze it.
      if (!st_reg.strap_ok) begin
         if (st_reg.settle == cpu_clock_mode_pkg::STRAP_SETTLE) begin
            st_next.strap_ok = 1'b1;
            st_next.code     = strap_lvl;
         end else begin
            st_next.settle = st_reg.settle + 3'h1;
         end
      end

      // Decode the held code into the clock generation mode.
      st_next.mode = '{pll_clocks_cpu: 1'b1, osc_bypass: 1'b0, prescale: 1'b0,
                       factor: cpu_clock_mode_pkg::FACTOR_NONE};
      unique case (st_next.code)
         cpu_clock_mode_pkg::CODE_X4:  st_next.mode.factor = cpu_clock_mode_pkg::FACTOR_X4;
         cpu_clock_mode_pkg::CODE_X3:  st_next.mode.factor = cpu_clock_mode_pkg::FACTOR_X3;
         cpu_clock_mode_pkg::CODE_X8:  st_next.mode.factor = cpu_clock_mode_pkg::FACTOR_X8;
         cpu_clock_mode_pkg::CODE_X5:  st_next.mode.factor = cpu_clock_mode_pkg::FACTOR_X5;
         cpu_clock_mode_pkg::CODE_X10: st_next.mode.factor = cpu_clock_mode_pkg::FACTOR_X10;
         cpu_clock_mode_pkg::CODE_X16: st_next.mode.factor = cpu_clock_mode_pkg::FACTOR_X16;
         cpu_clock_mode_pkg::CODE_DIRECT: begin
            st_next.mode.pll_clocks_cpu = 1'b0;
            st_next.mode.osc_bypass     = 1'b1;
            st_next.mode.factor         = cpu_clock_mode_pkg::FACTOR_X1;
         end
         cpu_clock_mode_pkg::CODE_PRESCALE: begin
            st_next.mode.pll_clocks_cpu = 1'b0;
            st_next.mode.prescale       = 1'b1;
         end
      endcase

      // Watchdog: clear while inactive or on any input transition, count PLL cycles otherwise.
      if (!wd_active || in_edge) begin
         st_next.wd_cnt = 5'h00;
      end else if (pll_rise) begin
         st_next.wd_cnt = st_reg.wd_cnt + 5'h01;
         if (st_next.wd_cnt == cpu_clock_mode_pkg::WD_OVERFLOW) begin
            st_next.failover = 1'b1;
            st_next.irq      = 1'b1;
            st_next.wd_cnt   = 5'h00;
         end
      end

      // Divide-by-two: toggling on rising input edges makes each phase one
      // full input period regardless of the input duty cycle.
      if (in_rise) begin
         st_next.div_clk = !st_reg.div_clk;
      end

      // Source select; once failed over only reset brings the input back.
      if (st_reg.failover || st_reg.mode.pll_clocks_cpu) begin
         st_next.cpu_clk = pll_out_i;
      end else if (st_reg.mode.prescale) begin
         st_next.cpu_clk = st_reg.div_clk;
      end else begin
         st_next.cpu_clk = in_lvl;
      end
      // Each edge, rising or falling, opens a new half period.
      st_next.cpu_edge = st_next.cpu_clk != st_reg.cpu_clk;

      // PLL power: on when it clocks the CPU, free-runs for the watchdog,
      // and is switched off only when the watchdog is disabled.
      st_next.pll_en = st_next.mode.pll_clocks_cpu || st_next.failover ||
                       !osc_watchdog_disable_i;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '{strap_ok: 1'b0, code: cpu_clock_mode_pkg::CODE_DEFAULT,
                     settle: 3'h0, in_prev: 1'b0, pll_prev: 1'b0, wd_cnt: 5'h00,
                     failover: 1'b0, irq: 1'b0, div_clk: 1'b0, cpu_clk: 1'b0,
                     cpu_edge: 1'b0,
                     mode: '{pll_clocks_cpu: 1'b1, osc_bypass: 1'b0, prescale: 1'b0,
                             factor: cpu_clock_mode_pkg::FACTOR_X4},
                     pll_en: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register.
   assign cpu_clk_o    = st_reg.cpu_clk;
   assign cpu_edge_o   = st_reg.cpu_edge;
   assign mode_o       = st_reg.mode;
   assign mode_valid_o = st_reg.strap_ok;
   assign pll_enable_o = st_reg.pll_en;
   assign failover_o   = st_reg.failover;
   assign owd_irq_o    = st_reg.irq;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_strap_held: assert property (
      st_reg.strap_ok |=> st_reg.strap_ok && $stable(st_reg.code))
      else $error("Strap code changed after capture.");
   chk_strap_latch: assert property (
      !st_reg.strap_ok && st_reg.settle == cpu_clock_mode_pkg::STRAP_SETTLE
      |=> st_reg.strap_ok && st_reg.code == $past(strap_lvl))
      else $error("Strap not captured from the synchronised pins.");
   chk_factor_x16: assert property (
      st_reg.strap_ok && st_reg.code == cpu_clock_mode_pkg::CODE_X16
      |-> mode_o.factor == cpu_clock_mode_pkg::FACTOR_X16 && mode_o.pll_clocks_cpu)
      else $error("Code 000 does not select x16.");
   chk_factor_x10: assert property (
      st_reg.strap_ok && st_reg.code == cpu_clock_mode_pkg::CODE_X10
      |-> mode_o.factor == cpu_clock_mode_pkg::FACTOR_X10)
      else $error("Code 010 does not select x10.");
   chk_direct_follow: assert property (
      st_reg.strap_ok && mode_o.osc_bypass && !st_reg.failover
      |=> cpu_clk_o == $past(in_lvl))
      else $error("Direct drive clock does not follow the input.");
   chk_prescale_phase: assert property (
      st_reg.strap_ok && mode_o.prescale && !st_reg.failover && in_rise
      |=> ##1 cpu_clk_o != $past(cpu_clk_o))
      else $error("Prescaled clock missed an input period.");
   chk_pll_freerun: assert property (
      st_reg.strap_ok && non_pll && !osc_watchdog_disable_i |=> pll_enable_o)
      else $error("PLL stopped while the watchdog needs it.");
   chk_pll_off: assert property (
      st_reg.strap_ok && non_pll && osc_watchdog_disable_i && !st_reg.failover
      |=> !pll_enable_o)
      else $error("PLL left running with watchdog disabled.");
   chk_edge_mark: assert property (
      $changed(cpu_clk_o) |-> cpu_edge_o)
      else $error("CPU clock edge not marked.");
   chk_wd_clear: assert property (
      in_edge |=> st_reg.wd_cnt == 5'h00)
      else $error("Watchdog counter not cleared by input transition.");
   chk_wd_overflow: assert property (
      wd_active && !in_edge && pll_rise && st_reg.wd_cnt == 5'h0f
      |=> failover_o && owd_irq_o ##1 !owd_irq_o)
      else $error("Watchdog overflow did not fail over.");
   chk_failover_hold: assert property (
      failover_o |=> failover_o ##1 cpu_clk_o == $past(pll_out_i))
      else $error("Fail-over released or CPU clock left the PLL.");

   cov_failover: cover property (!failover_o ##1 failover_o);
   cov_prescale: cover property (mode_valid_o && mode_o.prescale && cpu_edge_o);
   cov_direct:   cover property (mode_valid_o && mode_o.osc_bypass && cpu_edge_o);
   cov_pll_off:  cover property (mode_valid_o && !pll_enable_o);

endmodule

// ### verification/clock_source_model.sv
/*
 * Far-side model: an external crystal or clock source on the input clock pin
 * and the PLL output level that the selector samples.
 * Assumes the bench steers it on the falling edge of sys_clk_i.
 */
`timescale 1ns/1ns
module clock_source_model (
   // Clock
   input  wire logic       sys_clk_i,
   // Controls from the bench
   input  wire logic       run_i,
   input  wire logic [7:0] half_i,
   input  wire logic       pll_enable_i,
   // Far-side levels
   output logic            input_clock_o,
   output logic            pll_out_o
);
   logic [7:0] cnt_reg;
   logic [1:0] pll_cnt_reg;

   // ----------------------------------------------------------------------
   // Oscillator and PLL
   // ----------------------------------------------------------------------
   // Both outputs move only on the falling edge, away from the sampling edge.
   initial begin
      cnt_reg       = 8'h00;
      pll_cnt_reg   = 2'h0;
      input_clock_o = 1'b0;
      pll_out_o     = 1'b0;
   end

   // A stopped crystal just holds its level; a powered-down PLL sits low.
   always @(negedge sys_clk_i) begin
      if (run_i) begin
         if (cnt_reg + 8'h01 >= half_i) begin
            cnt_reg       <= 8'h00;
            input_clock_o <= ~input_clock_o;
         end else begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
      pll_cnt_reg <= pll_cnt_reg + 2'h1;
      pll_out_o   <= pll_enable_i & pll_cnt_reg[1]; // Free-running period is 4 cycles.
   end
endmodule

// ### verification/cpu_clock_mode_select_test.sv
/*
 * Self-checking bench for the CPU clock mode selector: strap decode, direct
 * drive, prescaler phases, watchdog fail-over and its stickiness.
 * Assumes the clock_source_model partner drives the input clock and PLL.
 */
`timescale 1ns/1ns
module cpu_clock_mode_select_test;
   logic                          sys_clk_i;
   logic                          rst_n_i;
   logic [2:0]                    strap;
   logic                          dis;
   logic                          run;
   logic [7:0]                    half;
   logic                          in_clk;
   logic                          pll;
   logic                          cpu_clk;
   logic                          cpu_edge;
   logic                          mode_valid;
   logic                          pll_en;
   logic                          failover;
   logic                          irq;
   cpu_clock_mode_pkg::clk_mode_t mode;
   logic [15:0]                   len;
   logic [15:0]                   edges;
   int                            fails;
   int                            n_checks;
   int                            cycles;

   // ----------------------------------------------------------------------
   // Instances
   // ----------------------------------------------------------------------
   cpu_clock_mode_select DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .config_port_high_i(strap), .input_clock_pin_i(in_clk), .pll_out_i(pll),
      .osc_watchdog_disable_i(dis), .cpu_clk_o(cpu_clk), .cpu_edge_o(cpu_edge),
      .mode_o(mode), .mode_valid_o(mode_valid), .pll_enable_o(pll_en),
      .failover_o(failover), .owd_irq_o(irq));
   clock_source_model src (.sys_clk_i(sys_clk_i), .run_i(run), .half_i(half),
      .pll_enable_i(pll_en), .input_clock_o(in_clk), .pll_out_o(pll));

   // ----------------------------------------------------------------------
   // Clock, watchdog on the run and compare tasks
   // ----------------------------------------------------------------------
   // The ceiling sits far above the well under two thousand cycles the tests need.
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_of_test();
      end
   end

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_mode(input cpu_clock_mode_pkg::clk_mode_t got,
                             input cpu_clock_mode_pkg::clk_mode_t exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t mode got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (fails == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Expected decode, written straight from the strap table.
   function automatic cpu_clock_mode_pkg::clk_mode_t exp_mode(input logic [2:0] c);
      case (c)
         3'h7: exp_mode = {3'b100, cpu_clock_mode_pkg::FACTOR_X4};
         3'h6: exp_mode = {3'b100, cpu_clock_mode_pkg::FACTOR_X3};
         3'h5: exp_mode = {3'b100, cpu_clock_mode_pkg::FACTOR_X8};
         3'h4: exp_mode = {3'b100, cpu_clock_mode_pkg::FACTOR_X5};
         3'h3: exp_mode = {3'b010, cpu_clock_mode_pkg::FACTOR_X1};
         3'h2: exp_mode = {3'b100, cpu_clock_mode_pkg::FACTOR_X10};
         3'h1: exp_mode = {3'b001, cpu_clock_mode_pkg::FACTOR_NONE};
         default: exp_mode = {3'b100, cpu_clock_mode_pkg::FACTOR_X16};
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Shared sequences
   // ----------------------------------------------------------------------
   // Strap is set as reset goes low so it is settled long before capture.
   task automatic do_reset(input logic [2:0] code);
      int i;
      @(negedge sys_clk_i);
      rst_n_i = 1'b0;
      strap   = code;
      repeat (8) @(negedge sys_clk_i);
      check_mode(mode, exp_mode(3'h7));
      check_val({15'h0, pll_en}, 16'h0001);
      check_val({14'h0, failover, mode_valid}, 16'h0000);
      rst_n_i = 1'b1;
      for (i = 0; i < 20 && mode_valid !== 1'b1; i++) @(negedge sys_clk_i);
      check_val({15'h0, mode_valid}, 16'h0001);
   endtask

   // Length of the next full phase at level lvl, and edge pulses inside it.
   task automatic phase_len(input logic lvl, output logic [15:0] n, output logic [15:0] e);
      int i;
      n = 16'h0000;
      e = 16'h0000;
      for (i = 0; i < 300 && cpu_clk !== ~lvl; i++) @(negedge sys_clk_i);
      for (i = 0; i < 300 && cpu_clk !== lvl; i++) @(negedge sys_clk_i);
      for (i = 0; i < 300 && cpu_clk === lvl; i++) begin
         n = n + 16'h0001;
         e = e + {15'h0, cpu_edge === 1'b1};
         @(negedge sys_clk_i);
      end
   endtask

   // After fail-over or in PLL mode the CPU clock is the sampled PLL level.
   task automatic check_follow(input int n);
      repeat (n) begin
         @(negedge sys_clk_i);
         check_val({15'h0, cpu_clk}, {15'h0, pll});
      end
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic test_straps();
      int c;
      for (c = 0; c < 8; c++) begin
         do_reset(c[2:0]);
         check_mode(mode, exp_mode(c[2:0]));
         check_val({15'h0, pll_en}, 16'h0001);
         strap = ~c[2:0];
         repeat (10) @(negedge sys_clk_i);
         check_mode(mode, exp_mode(c[2:0]));
      end
   endtask

   task automatic test_prescale();
      do_reset(3'h1);
      phase_len(1'b1, len, edges);
      check_val(len, {7'h0, half, 1'b0});
      check_val(edges, 16'h0001);
      phase_len(1'b0, len, edges);
      check_val(len, {7'h0, half, 1'b0});
      check_val(edges, 16'h0001);
      dis = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      check_val({15'h0, pll_en}, 16'h0000);
      run = 1'b0;
      repeat (200) @(negedge sys_clk_i);
      check_val({15'h0, failover}, 16'h0000);
      run = 1'b1;
      repeat (40) @(negedge sys_clk_i);
      dis = 1'b0;
   endtask

   task automatic test_direct_failover();
      int i;
      do_reset(3'h3);
      phase_len(1'b1, len, edges);
      check_val(len, {8'h0, half});
      phase_len(1'b0, len, edges);
      check_val(len, {8'h0, half});
      half = 8'd50; // 12 to 13 PLL rises between transitions, just under overflow.
      repeat (400) @(negedge sys_clk_i);
      check_val({15'h0, failover}, 16'h0000);
      run = 1'b0;
      for (i = 0; i < 200 && irq !== 1'b1; i++) @(negedge sys_clk_i);
      check_val({14'h0, failover, irq}, 16'h0003);
      @(negedge sys_clk_i);
      check_val({15'h0, irq}, 16'h0000);
      check_follow(40);
      half = 8'd10;
      run  = 1'b1;
      repeat (100) @(negedge sys_clk_i);
      check_val({14'h0, failover, pll_en}, 16'h0003);
      check_follow(40);
   endtask

   task automatic test_pll_mode();
      do_reset(3'h7);
      check_follow(40);
      run = 1'b0;
      repeat (200) @(negedge sys_clk_i);
      check_val({15'h0, failover}, 16'h0000);
      run = 1'b1;
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst_n_i  = 1'b0;
      strap    = 3'h7;
      dis      = 1'b0;
      run      = 1'b1;
      half     = 8'd10;
      fails    = 0;
      n_checks = 0;
      cycles   = 0;
      test_straps();
      test_prescale();
      test_direct_failover();
      test_pll_mode();
      end_of_test();
   end
endmodule
